// >>> hw/uart_trig_pkg.sv
// uart decode trigger package: register map, fields, resets, modes, timing
package uart_trig_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIV = 8'h04;
	localparam logic [7:0] ADDR_IDLE = 8'h08;
	localparam logic [7:0] ADDR_POS = 8'h0c;
	localparam logic [7:0] ADDR_PAT0 = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_LAST = 8'h24;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_POL_BIT = 1;
	localparam int CTRL_PAR_LSB = 2;
	localparam int CTRL_STOP_LSB = 4;
	localparam int CTRL_DBITS_LSB = 6;
	localparam int CTRL_TXEN_BIT = 10;
	localparam int CTRL_SRC_BIT = 11;
	localparam int CTRL_MODE_LSB = 12;
	localparam int CTRL_PRESET_LSB = 16;
	localparam int POS_CNT_LSB = 12;
	localparam int POS_NTH_LSB = 16;
	localparam int PAT_MASK_LSB = 16;
	localparam int ST_TRIG_BIT = 0;
	localparam int ST_RXBUSY_BIT = 1;
	localparam int ST_TXBUSY_BIT = 2;
	localparam int ST_FRM_BIT = 3;
	localparam int ST_PAR_BIT = 4;
	localparam int ST_BRK_BIT = 5;
	localparam int IDX_LSB = 16;
	localparam logic [19:0] CTRL_RST = 20'h00200;
	localparam logic [23:0] DIV_RST = 24'h00087a;
	localparam logic [23:0] IDLE_RST = 24'h005000;
	localparam logic [23:0] DIV_MIN = 24'h000004;
	localparam logic [3:0] DBITS_MIN = 4'h5;
	localparam logic [3:0] DBITS_MAX = 4'h9;
	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_type;
	typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} stop_type;
	typedef enum logic [2:0] {TRIG_START, TRIG_FRAME_START, TRIG_FRAME_ERR, TRIG_SYMBOL,
		TRIG_BREAK, TRIG_PARITY, TRIG_PATTERN, TRIG_ANY} trig_mode_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP1, RX_STOP2,
		RX_BREAK} rx_state_type;
	// preset bit rates, index 0 selects the user divider
	function automatic logic [23:0] preset_div(input logic [3:0] sel);
		case (sel)
			4'h1: return 24'(CLK_HZ / 300);
			4'h2: return 24'(CLK_HZ / 600);
			4'h3: return 24'(CLK_HZ / 1200);
			4'h4: return 24'(CLK_HZ / 2400);
			4'h5: return 24'(CLK_HZ / 4800);
			4'h6: return 24'(CLK_HZ / 9600);
			4'h7: return 24'(CLK_HZ / 19200);
			4'h8: return 24'(CLK_HZ / 38400);
			4'h9: return 24'(CLK_HZ / 57600);
			4'ha: return 24'(CLK_HZ / 115200);
			4'hb: return 24'(CLK_HZ / 230400);
			4'hc: return 24'(CLK_HZ / 460800);
			4'hd: return 24'(CLK_HZ / 921600);
			4'he: return 24'(CLK_HZ / 1000000);
			default: return 24'h000000;
		endcase
	endfunction
endpackage

// >>> hw/uart_decode_trigger.sv
// uart decode trigger: symbol receivers, trigger logic and avalon register slave
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module uart_sym_rx (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_enable,
	input wire logic i_line,
	input wire logic [23:0] i_div,
	input wire logic [3:0] i_dbits,
	input wire logic [1:0] i_parity,
	input wire logic [1:0] i_stop,
	input wire logic [23:0] i_idle,
	output logic o_start,
	output logic o_frame_start,
	output logic o_sym_done,
	output logic o_par_err,
	output logic o_frm_err,
	output logic o_brk,
	output logic o_busy,
	output logic [8:0] o_sym_data,
	output logic [11:0] o_sym_idx
);
	uart_trig_pkg::rx_state_type state_r, state_nxt;
	logic [23:0] cnt_r, cnt_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [8:0] data_r, data_nxt;
	logic zero_r, zero_nxt;
	logic par_r, par_nxt;
	logic [23:0] gap_r, gap_nxt;
	logic open_r, open_nxt;
	logic [11:0] idx_r, idx_nxt;
	logic start_nxt, fstart_nxt, done_nxt, perr_nxt, ferr_nxt, brk_nxt;
	logic [8:0] sdata_nxt;
	logic [11:0] sidx_nxt;
	wire tick = (cnt_r == 24'h000000);
	wire [23:0] cnt_dec = cnt_r - 24'h000001;
	wire [23:0] full_load = i_div - 24'h000001;
	wire [23:0] half_load = (i_div >> 1) - 24'h000001;
	wire [23:0] half_stop_load = (i_div >> 1) + (i_div >> 2) - 24'h000001;
	wire par_bad = (i_parity == uart_trig_pkg::PAR_EVEN) ? (par_r ^ i_line) :
		(i_parity == uart_trig_pkg::PAR_ODD) ? ~(par_r ^ i_line) : 1'b0;
	wire gap_full = (gap_r >= i_idle);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = tick ? cnt_r : cnt_dec;
		bit_nxt = bit_r;
		data_nxt = data_r;
		zero_nxt = zero_r;
		par_nxt = par_r;
		gap_nxt = gap_r;
		open_nxt = open_r;
		idx_nxt = idx_r;
		start_nxt = 1'b0;
		fstart_nxt = 1'b0;
		done_nxt = 1'b0;
		perr_nxt = 1'b0;
		ferr_nxt = 1'b0;
		brk_nxt = 1'b0;
		sdata_nxt = o_sym_data;
		sidx_nxt = o_sym_idx;
		unique case (state_r)
			uart_trig_pkg::RX_IDLE: begin
				if (i_line && gap_r != 24'hffffff) begin
					gap_nxt = gap_r + 24'h000001;
				end
				if (i_enable && !i_line) begin
					state_nxt = uart_trig_pkg::RX_START;
					cnt_nxt = half_load;
				end
			end
			uart_trig_pkg::RX_START: begin
				if (tick) begin
					if (i_line) begin
						state_nxt = uart_trig_pkg::RX_IDLE;
					end else begin
						state_nxt = uart_trig_pkg::RX_DATA;
						cnt_nxt = full_load;
						bit_nxt = 4'h0;
						data_nxt = 9'h000;
						zero_nxt = 1'b1;
						par_nxt = 1'b0;
						start_nxt = 1'b1;
						fstart_nxt = !open_r || gap_full;
						if (!open_r || gap_full) begin
							idx_nxt = 12'h000;
						end
						open_nxt = 1'b1;
						gap_nxt = 24'h000000;
					end
				end
			end
			uart_trig_pkg::RX_DATA: begin
				if (tick) begin
					data_nxt[bit_r] = i_line;
					par_nxt = par_r ^ i_line;
					zero_nxt = zero_r & ~i_line;
					cnt_nxt = full_load;
					bit_nxt = bit_r + 4'h1;
					if (bit_r == i_dbits - 4'h1) begin
						state_nxt = (i_parity == uart_trig_pkg::PAR_EVEN ||
							i_parity == uart_trig_pkg::PAR_ODD) ?
							uart_trig_pkg::RX_PARITY : uart_trig_pkg::RX_STOP1;
					end
				end
			end
			uart_trig_pkg::RX_PARITY: begin
				if (tick) begin
					perr_nxt = par_bad;
					zero_nxt = zero_r & ~i_line;
					cnt_nxt = full_load;
					state_nxt = uart_trig_pkg::RX_STOP1;
				end
			end
			uart_trig_pkg::RX_STOP1: begin
				if (tick) begin
					ferr_nxt = !i_line;
					if (!i_line && zero_r) begin
						brk_nxt = 1'b1;
						state_nxt = uart_trig_pkg::RX_BREAK;
					end else if (i_stop == uart_trig_pkg::STOP_1) begin
						state_nxt = uart_trig_pkg::RX_IDLE;
						done_nxt = 1'b1;
						sdata_nxt = data_r;
						sidx_nxt = idx_r;
						idx_nxt = idx_r + 12'h001;
					end else begin
						state_nxt = uart_trig_pkg::RX_STOP2;
						cnt_nxt = (i_stop == uart_trig_pkg::STOP_1P5) ? half_stop_load :
							full_load;
					end
				end
			end
			uart_trig_pkg::RX_STOP2: begin
				if (tick) begin
					ferr_nxt = !i_line;
					state_nxt = uart_trig_pkg::RX_IDLE;
					done_nxt = 1'b1;
					sdata_nxt = data_r;
					sidx_nxt = idx_r;
					idx_nxt = idx_r + 12'h001;
				end
			end
			uart_trig_pkg::RX_BREAK: begin
				if (i_line) begin
					state_nxt = uart_trig_pkg::RX_IDLE;
				end
			end
			default: begin
				state_nxt = uart_trig_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= uart_trig_pkg::RX_IDLE;
			cnt_r <= 24'h000000;
			bit_r <= 4'h0;
			data_r <= 9'h000;
			zero_r <= 1'b0;
			par_r <= 1'b0;
			gap_r <= 24'h000000;
			open_r <= 1'b0;
			idx_r <= 12'h000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			data_r <= data_nxt;
			zero_r <= zero_nxt;
			par_r <= par_nxt;
			gap_r <= gap_nxt;
			open_r <= open_nxt;
			idx_r <= idx_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_start <= 1'b0;
			o_frame_start <= 1'b0;
			o_sym_done <= 1'b0;
			o_par_err <= 1'b0;
			o_frm_err <= 1'b0;
			o_brk <= 1'b0;
			o_sym_data <= 9'h000;
			o_sym_idx <= 12'h000;
		end else begin
			o_start <= start_nxt;
			o_frame_start <= fstart_nxt;
			o_sym_done <= done_nxt;
			o_par_err <= perr_nxt;
			o_frm_err <= ferr_nxt;
			o_brk <= brk_nxt;
			o_sym_data <= sdata_nxt;
			o_sym_idx <= sidx_nxt;
		end
	end

	assign o_busy = (state_r != uart_trig_pkg::RX_IDLE);
endmodule

module uart_decode_trigger (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_rx,
	input wire logic i_tx,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_trigger,
	output logic o_triggered
);
	// byte-enable merge of a register word
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// symbol compare over the active data width, mask one means compare
	function automatic logic sym_match(input logic [8:0] data, input logic [24:0] pat,
		input logic [3:0] dbits);
		logic [8:0] wmask;
		wmask = 9'h1ff >> (4'h9 - dbits);
		return (((data ^ pat[8:0]) & pat[uart_trig_pkg::PAT_MASK_LSB +: 9] & wmask) == 9'h000);
	endfunction

	logic [19:0] ctrl_r;
	logic [23:0] div_r;
	logic [23:0] idle_r;
	logic [27:0] pos_r;
	logic [24:0] pat_r [0:3];
	logic [5:0] sticky_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic rx_s1_r, rx_s2_r, tx_s1_r, tx_s2_r;
	logic run_r, run_nxt;
	logic trig_r;

	// avalon slave: one wait cycle, then the answer
	wire req = i_avs_read | i_avs_write;
	wire wr_go = i_avs_write & ack_r;
	wire rd_take = i_avs_read & ~ack_r;
	wire [5:0] wsel = i_avs_address[7:2];
	wire hit_ctrl = (wsel == uart_trig_pkg::ADDR_CTRL[7:2]);
	wire hit_div = (wsel == uart_trig_pkg::ADDR_DIV[7:2]);
	wire hit_idle = (wsel == uart_trig_pkg::ADDR_IDLE[7:2]);
	wire hit_pos = (wsel == uart_trig_pkg::ADDR_POS[7:2]);
	wire hit_pat = (i_avs_address[7:4] == uart_trig_pkg::ADDR_PAT0[7:4]);
	wire hit_status = (wsel == uart_trig_pkg::ADDR_STATUS[7:2]);
	wire hit_last = (wsel == uart_trig_pkg::ADDR_LAST[7:2]);
	wire [1:0] pat_sel = i_avs_address[3:2];

	// configuration fields
	wire cfg_en = ctrl_r[uart_trig_pkg::CTRL_EN_BIT];
	wire cfg_pol = ctrl_r[uart_trig_pkg::CTRL_POL_BIT];
	wire [1:0] cfg_par = ctrl_r[uart_trig_pkg::CTRL_PAR_LSB +: 2];
	wire [1:0] cfg_stop = ctrl_r[uart_trig_pkg::CTRL_STOP_LSB +: 2];
	wire [3:0] cfg_dbits_raw = ctrl_r[uart_trig_pkg::CTRL_DBITS_LSB +: 4];
	wire cfg_txen = ctrl_r[uart_trig_pkg::CTRL_TXEN_BIT];
	wire cfg_src_tx = ctrl_r[uart_trig_pkg::CTRL_SRC_BIT] & cfg_txen;
	wire [2:0] cfg_mode = ctrl_r[uart_trig_pkg::CTRL_MODE_LSB +: 3];
	wire [3:0] cfg_preset = ctrl_r[uart_trig_pkg::CTRL_PRESET_LSB +: 4];
	wire [3:0] dbits = (cfg_dbits_raw < uart_trig_pkg::DBITS_MIN) ? uart_trig_pkg::DBITS_MIN :
		(cfg_dbits_raw > uart_trig_pkg::DBITS_MAX) ? uart_trig_pkg::DBITS_MAX :
		cfg_dbits_raw;
	wire [23:0] div_sel = (cfg_preset == 4'h0) ? div_r :
		uart_trig_pkg::preset_div(cfg_preset);
	wire [23:0] div_eff = (div_sel < uart_trig_pkg::DIV_MIN) ? uart_trig_pkg::DIV_MIN : div_sel;
	wire [11:0] pat_off = pos_r[11:0];
	wire [1:0] pat_last = pos_r[uart_trig_pkg::POS_CNT_LSB +: 2];
	wire [11:0] nth = pos_r[uart_trig_pkg::POS_NTH_LSB +: 12];

	// polarity applied to both lines
	wire rx_line = rx_s2_r ^ cfg_pol;
	wire tx_line = tx_s2_r ^ cfg_pol;

	logic rx_start, rx_fstart, rx_done, rx_perr, rx_ferr, rx_brk, rx_busy;
	logic tx_start, tx_fstart, tx_done, tx_perr, tx_ferr, tx_brk, tx_busy;
	logic [8:0] rx_data, tx_data;
	logic [11:0] rx_idx, tx_idx;

	uart_sym_rx u_rx (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_enable(cfg_en),
		.i_line(rx_line),
		.i_div(div_eff),
		.i_dbits(dbits),
		.i_parity(cfg_par),
		.i_stop(cfg_stop),
		.i_idle(idle_r),
		.o_start(rx_start),
		.o_frame_start(rx_fstart),
		.o_sym_done(rx_done),
		.o_par_err(rx_perr),
		.o_frm_err(rx_ferr),
		.o_brk(rx_brk),
		.o_busy(rx_busy),
		.o_sym_data(rx_data),
		.o_sym_idx(rx_idx)
	);

	uart_sym_rx u_tx (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_enable(cfg_en & cfg_txen),
		.i_line(tx_line),
		.i_div(div_eff),
		.i_dbits(dbits),
		.i_parity(cfg_par),
		.i_stop(cfg_stop),
		.i_idle(idle_r),
		.o_start(tx_start),
		.o_frame_start(tx_fstart),
		.o_sym_done(tx_done),
		.o_par_err(tx_perr),
		.o_frm_err(tx_ferr),
		.o_brk(tx_brk),
		.o_busy(tx_busy),
		.o_sym_data(tx_data),
		.o_sym_idx(tx_idx)
	);

	// trigger source selection
	wire s_start = cfg_src_tx ? tx_start : rx_start;
	wire s_fstart = cfg_src_tx ? tx_fstart : rx_fstart;
	wire s_done = cfg_src_tx ? tx_done : rx_done;
	wire s_perr = cfg_src_tx ? tx_perr : rx_perr;
	wire s_ferr = cfg_src_tx ? tx_ferr : rx_ferr;
	wire s_brk = cfg_src_tx ? tx_brk : rx_brk;
	wire [8:0] s_data = cfg_src_tx ? tx_data : rx_data;
	wire [11:0] s_idx = cfg_src_tx ? tx_idx : rx_idx;

	// pattern window tracking
	wire [11:0] pat_pos = s_idx - pat_off;
	wire in_win = (s_idx >= pat_off) && (pat_pos <= {10'h000, pat_last});
	wire pos_match = sym_match(s_data, pat_r[pat_pos[1:0]], dbits);
	wire run_all = (pat_pos == 12'h000) ? pos_match : (run_r & pos_match);
	wire pat_hit = s_done && in_win && run_all && (pat_pos[1:0] == pat_last);
	wire any_hit = s_done && sym_match(s_data, pat_r[0], dbits);

	logic trig_nxt;
	always_comb begin
		run_nxt = run_r;
		if (s_done && in_win) begin
			run_nxt = run_all;
		end
		unique case (cfg_mode)
			uart_trig_pkg::TRIG_START: trig_nxt = s_start;
			uart_trig_pkg::TRIG_FRAME_START: trig_nxt = s_start & s_fstart;
			uart_trig_pkg::TRIG_FRAME_ERR: trig_nxt = s_ferr;
			uart_trig_pkg::TRIG_SYMBOL: trig_nxt = s_done && (s_idx == nth);
			uart_trig_pkg::TRIG_BREAK: trig_nxt = s_brk;
			uart_trig_pkg::TRIG_PARITY: trig_nxt = s_perr;
			uart_trig_pkg::TRIG_PATTERN: trig_nxt = pat_hit;
			uart_trig_pkg::TRIG_ANY: trig_nxt = any_hit;
		endcase
	end

	// sticky status events, set wins over write-one-to-clear
	wire [5:0] ev_set = {s_brk, s_perr, s_ferr, 2'b00, trig_r};
	wire [5:0] w1c = (wr_go && hit_status && i_avs_byteenable[0]) ?
		i_avs_writedata[5:0] : 6'h00;
	wire [5:0] sticky_nxt = (sticky_r & ~w1c & 6'h39) | ev_set;

	wire [31:0] pat_word = {7'h00, pat_r[pat_sel]};
	wire [31:0] status_word = {4'h0, s_idx, 10'h000, sticky_r[5:3], tx_busy, rx_busy,
		sticky_r[0]};
	wire [31:0] rd_mux = hit_ctrl ? {12'h000, ctrl_r} :
		hit_div ? {8'h00, div_r} :
		hit_idle ? {8'h00, idle_r} :
		hit_pos ? {4'h0, pos_r} :
		hit_pat ? pat_word :
		hit_status ? status_word :
		hit_last ? {4'h0, s_idx, 7'h00, s_data} : 32'h00000000;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			tx_s1_r <= 1'b1;
			tx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= i_rx;
			rx_s2_r <= rx_s1_r;
			tx_s1_r <= i_tx;
			tx_s2_r <= tx_s1_r;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= req & ~ack_r;
			if (rd_take) begin
				rdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_r <= uart_trig_pkg::CTRL_RST;
			div_r <= uart_trig_pkg::DIV_RST;
			idle_r <= uart_trig_pkg::IDLE_RST;
			pos_r <= 28'h0000000;
		end else if (wr_go) begin
			if (hit_ctrl) begin
				ctrl_r <= 20'(be_merge({12'h000, ctrl_r}, i_avs_writedata, i_avs_byteenable));
			end
			if (hit_div) begin
				div_r <= 24'(be_merge({8'h00, div_r}, i_avs_writedata, i_avs_byteenable));
			end
			if (hit_idle) begin
				idle_r <= 24'(be_merge({8'h00, idle_r}, i_avs_writedata, i_avs_byteenable));
			end
			if (hit_pos) begin
				pos_r <= 28'(be_merge({4'h0, pos_r}, i_avs_writedata, i_avs_byteenable));
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 4; i++) begin
				pat_r[i] <= 25'h0000000;
			end
		end else if (wr_go && hit_pat) begin
			pat_r[pat_sel] <= 25'(be_merge(pat_word, i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sticky_r <= 6'h00;
			run_r <= 1'b0;
			trig_r <= 1'b0;
		end else begin
			sticky_r <= sticky_nxt;
			run_r <= run_nxt;
			trig_r <= trig_nxt & cfg_en;
		end
	end

	assign o_avs_waitrequest = req & ~ack_r;
	assign o_avs_readdata = rdata_r;
	assign o_trigger = trig_r;
	assign o_triggered = sticky_r[uart_trig_pkg::ST_TRIG_BIT];
endmodule

// >>> dv/uart_trig_checker.sv
// checker: bus handshake and trigger output properties
`timescale 1ns/1ps
module uart_trig_checker (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic i_rx,
	input wire logic i_tx,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic o_trigger,
	input wire logic o_triggered
);
	localparam int QUIET_MAX = 300;
	logic [8:0] quiet_r;
	logic [8:0] quiet_nxt;
	logic rx_d_r;
	logic tx_d_r;
	wire req = i_avs_read | i_avs_write;
	wire line_moved = (i_rx != rx_d_r) | (i_tx != tx_d_r);
	wire clr = i_avs_write & ~o_avs_waitrequest & (i_avs_address[7:2] == 6'h08)
		& i_avs_byteenable[0] & i_avs_writedata[0];
	wire unmapped = i_avs_address[7:2] > 6'h09;
	assign quiet_nxt = line_moved ? 9'h000 : (&quiet_r ? quiet_r : quiet_r + 9'h001);
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			quiet_r <= 9'h000;
			rx_d_r <= 1'b1;
			tx_d_r <= 1'b1;
		end else begin
			quiet_r <= quiet_nxt;
			rx_d_r <= i_rx;
			tx_d_r <= i_tx;
		end
	end
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_arst_n);
	property p_wait_start;
		$rose(req) |-> o_avs_waitrequest;
	endproperty
	property p_wait_one;
		req && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	property p_idle_nowait;
		!req |-> !o_avs_waitrequest;
	endproperty
	property p_unmapped_zero;
		i_avs_read && !o_avs_waitrequest && unmapped |-> o_avs_readdata == 32'h0;
	endproperty
	property p_rdata_stands;
		!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
	endproperty
	property p_trig_pulse;
		o_trigger |=> !o_trigger;
	endproperty
	property p_trig_sets;
		o_trigger |=> o_triggered;
	endproperty
	property p_sticky;
		o_triggered && !clr |=> o_triggered;
	endproperty
	property p_clear;
		clr |=> !o_triggered || o_trigger;
	endproperty
	property p_trig_cause;
		o_trigger |-> quiet_r < QUIET_MAX;
	endproperty
	a_wait_start: assert property (p_wait_start) else $error("no wait at request start");
	a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
	a_idle_nowait: assert property (p_idle_nowait) else $error("wait without request");
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger wider than one cycle");
	a_trig_sets: assert property (p_trig_sets) else $error("trigger not latched");
	a_sticky: assert property (p_sticky) else $error("latched trigger lost");
	a_clear: assert property (p_clear) else $error("latched trigger not cleared");
	a_trig_cause: assert property (p_trig_cause) else $error("trigger on quiet lines");
	c_trigger: cover property (o_trigger);
	c_clear: cover property (clr && o_triggered);
	c_unmapped: cover property (i_avs_read && !o_avs_waitrequest && unmapped);
endmodule
bind uart_decode_trigger uart_trig_checker uart_trig_checker_i (
	.i_clk_sys(i_clk_sys),
	.i_arst_n(i_arst_n),
	.i_rx(i_rx),
	.i_tx(i_tx),
	.i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest),
	.o_trigger(o_trigger),
	.o_triggered(o_triggered)
);

// >>> dv/uart_tx_model.sv
// serial transmitter model driving one observed line
`timescale 1ns/1ps
module uart_tx_model (
	input wire logic i_clk_sys,
	input wire logic i_pol,
	output logic o_line
);
	logic lvl = 1'b1;
	assign o_line = lvl ^ i_pol;
	task automatic put(input logic v, input int n);
		lvl <= v;
		repeat (n) @(posedge i_clk_sys);
	endtask
	// err: 1 wrong parity, 2 zero stop, 3 break
	task automatic send(input logic [8:0] d, input int nb, par, stp, div, err);
		logic p;
		if (err == 3) d = 9'h000;
		p = ^(d & 9'((1 << nb) - 1)) ^ (par == 2);
		if (err == 1) p = ~p;
		put(1'b0, div);
		for (int i = 0; i < nb; i++) put(d[i], div);
		if (par % 3 != 0) put(err == 3 ? 1'b0 : p, div);
		put(err < 2, stp == 0 ? div : (stp == 1 ? div * 3 / 2 : 2 * div));
		if (err == 3) put(1'b0, 2 * div);
		put(1'b1, 1);
	endtask
endmodule

// >>> dv/uart_decode_trigger_bench.sv
// self-checking bench for the serial decode trigger
`timescale 1ns/1ps
module uart_decode_trigger_bench;
	localparam logic [31:0] ALL = 32'hffffffff;
	localparam logic [31:0] LINES = (32'h1 << uart_trig_pkg::CTRL_POL_BIT)
		| (32'h1 << uart_trig_pkg::CTRL_TXEN_BIT) | (32'h1 << uart_trig_pkg::CTRL_SRC_BIT);
	logic i_clk_sys = 1'b0;
	logic i_arst_n = 1'b0;
	logic pol = 1'b0;
	logic [7:0] i_avs_address = 8'h00;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'h0;
	wire rx_line;
	wire tx_line;
	wire [31:0] o_avs_readdata;
	wire o_avs_waitrequest;
	wire o_trigger;
	wire o_triggered;
	logic [7:0] trig_cnt = 8'h00;
	logic [31:0] q;
	logic [8:0] pat_seq [6] = '{9'h011, 9'h03c, 9'h0f5, 9'h03c, 9'h0a5, 9'h000};
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	int div_now = 8;
	always #2 i_clk_sys = ~i_clk_sys;
	uart_decode_trigger uart_decode_trigger_i (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_rx(rx_line),
		.i_tx(tx_line),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_trigger(o_trigger),
		.o_triggered(o_triggered)
	);
	uart_tx_model rx_model_i (.i_clk_sys(i_clk_sys), .i_pol(pol), .o_line(rx_line));
	uart_tx_model tx_model_i (.i_clk_sys(i_clk_sys), .i_pol(pol), .o_line(tx_line));
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		trig_cnt <= trig_cnt + {7'h00, o_trigger};
		cycles++;
		if (cycles == 40000) begin
			fails++;
			results();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		i_avs_address <= a;
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		i_avs_writedata <= d;
		i_avs_byteenable <= 4'hf;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 100);
		if (o_avs_waitrequest !== 1'b0) fails++;
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check(q & m, exp);
	endtask
	function automatic logic [31:0] cfg(input int mode, par, stp, nb, input logic [31:0] x);
		return x | 32'h1 | 32'(mode << uart_trig_pkg::CTRL_MODE_LSB)
			| 32'(par << uart_trig_pkg::CTRL_PAR_LSB) | 32'(stp << uart_trig_pkg::CTRL_STOP_LSB)
			| 32'(nb << uart_trig_pkg::CTRL_DBITS_LSB);
	endfunction
	task automatic sym(input logic tx, input logic [8:0] d, input int nb, par, stp, err,
		input logic [7:0] exp);
		logic [7:0] base;
		base = trig_cnt;
		if (tx) tx_model_i.send(d, nb, par, stp, div_now, err);
		else rx_model_i.send(d, nb, par, stp, div_now, err);
		repeat (3 * div_now) @(posedge i_clk_sys);
		check(32'(trig_cnt - base), 32'(exp));
	endtask
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_arst_n <= 1'b1;
		rd_chk(uart_trig_pkg::ADDR_CTRL, ALL, 32'(uart_trig_pkg::CTRL_RST));
		rd_chk(uart_trig_pkg::ADDR_DIV, ALL, 32'(uart_trig_pkg::DIV_RST));
		rd_chk(uart_trig_pkg::ADDR_IDLE, ALL, 32'(uart_trig_pkg::IDLE_RST));
		rd_chk(uart_trig_pkg::ADDR_STATUS, ALL, 32'h0);
		wr(8'h40, ALL);
		rd_chk(8'h40, ALL, 32'h0);
		wr(uart_trig_pkg::ADDR_DIV, 32'h8);
		wr(uart_trig_pkg::ADDR_IDLE, 32'h64);
		rd_chk(uart_trig_pkg::ADDR_DIV, ALL, 32'h8);
		$display("test registers done");
		for (int nb = 5; nb <= 9; nb++) begin
			wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_PARITY, nb % 4, nb % 4, nb, 0));
			sym(0, 9'h1a5 ^ 9'(nb), nb, nb % 4, nb % 4, 0, 0);
			rd_chk(uart_trig_pkg::ADDR_LAST, 32'h1ff, 32'((9'h1a5 ^ 9'(nb)) & 9'((1 << nb) - 1)));
			if (nb % 4 % 3 != 0) sym(0, 9'h0c3, nb, nb % 4, nb % 4, 1, 1);
		end
		rd_chk(uart_trig_pkg::ADDR_STATUS, 32'h39, 32'h11);
		check(32'(o_triggered), 32'h1);
		wr(uart_trig_pkg::ADDR_STATUS, 32'h11);
		rd_chk(uart_trig_pkg::ADDR_STATUS, 32'h39, 32'h0);
		$display("test formats done");
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_FRAME_ERR, 0, 0, 8, 0));
		sym(0, 9'h055, 8, 0, 0, 0, 0);
		sym(0, 9'h055, 8, 0, 0, 2, 1);
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_BREAK, 1, 0, 8, 0));
		sym(0, 9'h055, 8, 1, 0, 0, 0);
		sym(0, 9'h000, 8, 1, 0, 3, 1);
		rd_chk(uart_trig_pkg::ADDR_STATUS, 32'h28, 32'h28);
		$display("test errors done");
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_START, 0, 0, 8, 0));
		sym(0, 9'h0ff, 8, 0, 0, 0, 1);
		sym(0, 9'h000, 8, 0, 0, 0, 1);
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_FRAME_START, 0, 0, 8, 0));
		repeat (200) @(posedge i_clk_sys);
		sym(0, 9'h081, 8, 0, 0, 0, 1);
		sym(0, 9'h081, 8, 0, 0, 0, 0);
		wr(uart_trig_pkg::ADDR_POS, 32'h2 << uart_trig_pkg::POS_NTH_LSB);
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_SYMBOL, 0, 0, 8, 0));
		repeat (200) @(posedge i_clk_sys);
		for (int k = 0; k < 4; k++) sym(0, 9'(k), 8, 0, 0, 0, 8'(k == 2));
		$display("test framing done");
		wr(uart_trig_pkg::ADDR_POS, 32'h1 | (32'h1 << uart_trig_pkg::POS_CNT_LSB));
		wr(uart_trig_pkg::ADDR_PAT0, 32'h01ff003c);
		wr(uart_trig_pkg::ADDR_PAT0 + 8'h04, 32'h000f00a5);
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_PATTERN, 0, 0, 8, 0));
		for (int i = 0; i < 6; i++) begin
			if (i % 3 == 0) repeat (200) @(posedge i_clk_sys);
			sym(0, pat_seq[i], 8, 0, 0, 0, 8'(i == 2));
		end
		wr(uart_trig_pkg::ADDR_PAT0, 32'h00f00030);
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_ANY, 0, 0, 8, 0));
		sym(0, 9'h012, 8, 0, 0, 0, 0);
		sym(0, 9'h13f, 8, 0, 0, 0, 1);
		sym(0, 9'h043, 8, 0, 0, 0, 0);
		$display("test patterns done");
		wr(uart_trig_pkg::ADDR_CTRL, 32'h0);
		pol <= 1'b1;
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_START, 0, 0, 8, LINES));
		sym(1, 9'h0a6, 8, 0, 0, 0, 1);
		sym(0, 9'h059, 8, 0, 0, 0, 0);
		rd_chk(uart_trig_pkg::ADDR_LAST, 32'h1ff, 32'h0a6);
		wr(uart_trig_pkg::ADDR_CTRL, 32'h0);
		pol <= 1'b0;
		div_now = uart_trig_pkg::CLK_HZ / 1000000;
		wr(uart_trig_pkg::ADDR_CTRL, cfg(uart_trig_pkg::TRIG_START, 0, 0, 8,
			32'he << uart_trig_pkg::CTRL_PRESET_LSB));
		sym(0, 9'h0c9, 8, 0, 0, 0, 1);
		rd_chk(uart_trig_pkg::ADDR_LAST, 32'h1ff, 32'h0c9);
		$display("test lines and rates done");
		results();
	end
endmodule
